// ===== src/sarx_pkg.sv
// shared constants, types and decode helpers for the serial audio receive block
package sarx_pkg;

    // register indices (byte address is four times the index)
    localparam logic [7:0]  RX_CFG_INDEX   = 8'h26;
    localparam logic [7:0]  CTRL_INDEX     = 8'h27;
    localparam logic [7:0]  STATUS_INDEX   = 8'h28;
    localparam logic [7:0]  DATA_PRI_INDEX = 8'h29;
    localparam logic [7:0]  DATA_SEC_INDEX = 8'h2A;

    localparam logic [11:0] RX_CFG_ADDR    = {2'h0, RX_CFG_INDEX, 2'h0};
    localparam logic [11:0] CTRL_ADDR      = {2'h0, CTRL_INDEX, 2'h0};
    localparam logic [11:0] STATUS_ADDR    = {2'h0, STATUS_INDEX, 2'h0};
    localparam logic [11:0] DATA_PRI_ADDR  = {2'h0, DATA_PRI_INDEX, 2'h0};
    localparam logic [11:0] DATA_SEC_ADDR  = {2'h0, DATA_SEC_INDEX, 2'h0};

    localparam logic [1:0]  HTRANS_NONSEQ  = 2'h2;

    typedef enum logic [1:0] {
        FMT_TDM = 2'b00,
        FMT_I2S = 2'b01,
        FMT_LJ  = 2'b10
    } fmt_type;

    typedef struct packed {
        logic       rx_sample_edge_select;
        logic       rx_internal_frame_sync_select;
        logic       rx_internal_bit_clock_select;
        logic [4:0] rx_msb_slot_offset;
    } rx_cfg_type;

    typedef struct packed {
        logic [1:0] word_len;
        logic [1:0] fmt;
        logic       bit_clock_polarity;
        logic       controller_mode;
    } ctrl_type;

    typedef struct packed {
        logic overrun;
        logic right;
        logic sec_valid;
        logic pri_valid;
    } status_type;

    typedef struct packed {
        logic        right;
        logic [31:0] pri;
        logic [31:0] sec;
    } rx_word_type;

    localparam rx_cfg_type RX_CFG_RESET  = 8'h00;
    localparam ctrl_type   CTRL_RESET    = 6'h00;
    localparam status_type STATUS_RESET  = 4'h0;

    // internal bit clock: link cycles per half period, bit clocks per frame
    localparam logic [3:0]  BCLK_HALF_DIV = 4'h4;
    localparam logic [6:0]  FRAME_BCLKS   = 7'h40;
    localparam logic [6:0]  HALF_FRAME    = 7'h20;
    localparam logic [6:0]  POS_MAX       = 7'h7F;

    function automatic logic [6:0] wl_bits(input logic [1:0] code);
        unique case (code)
            2'b00: wl_bits = 7'h10;
            2'b01: wl_bits = 7'h14;
            2'b10: wl_bits = 7'h18;
            2'b11: wl_bits = 7'h20;
        endcase
    endfunction : wl_bits

    function automatic logic reg_hit(input logic [11:0] addr, input logic [11:0] target);
        reg_hit = (addr == target);
    endfunction : reg_hit

endpackage : sarx_pkg

// ===== src/sarx_lane.sv
// one receive data lane: shift register and word capture
`timescale 1ns/1ns
module sarx_lane
    import sarx_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        rst_n_i,
    input  wire logic        din_i,
    input  wire logic        start_i,
    input  wire logic        shift_i,
    input  wire logic        done_i,
    output logic [31:0]      word_o
);

    logic [31:0] shreg;

    // a new slot clears stale bits so short words come out right-aligned
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            shreg <= 32'h0000_0000;
        end else if (shift_i && start_i) begin
            shreg <= {31'h0000_0000, din_i};
        end else if (shift_i) begin
            shreg <= {shreg[30:0], din_i};
        end else if (start_i) begin
            shreg <= 32'h0000_0000;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            word_o <= 32'h0000_0000;
        end else if (done_i) begin
            word_o <= {shreg[30:0], din_i}; // [R6]
        end
    end

    AST_LANE_CAPTURE: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [R6]
        done_i |=> (word_o[0] == $past(din_i)) && (word_o[31:1] == $past(shreg[30:0])))
        else $error("lane word not captured from shifted data");

endmodule : sarx_lane

// ===== src/sarx_top.sv
// serial audio receive port with latch configuration and AHB-Lite registers
//
// Local design decision: the AHB-Lite register port.
`timescale 1ns/1ns
// Operation
// R1 - edge select inverts latch edge, half cycle
// R2 - controller mode: internal or external frame sync
// R3 - controller mode: internal or external bit clock
// R4 - offset delays slot 0 MSB, 0..31
// R5 - offset shifts TDM slot 0, I2S/LJ both
// R6 - offset applies equally to both data pins
// R7 - far party places MSB at offset position
// R8 - target mode always latches with external clocks
module sarx_top
    import sarx_pkg::*;
(
    input  wire logic        REF_CLK_I,
    input  wire logic        RST_N_I,
    input  wire logic        HSEL_I,
    input  wire logic [31:0] HADDR_I,
    input  wire logic [1:0]  HTRANS_I,
    input  wire logic        HWRITE_I,
    input  wire logic [2:0]  HSIZE_I,
    input  wire logic [31:0] HWDATA_I,
    input  wire logic        HREADY_I,
    output logic [31:0]      HRDATA_O,
    output logic             HREADYOUT_O,
    output logic             HRESP_O,
    input  wire logic        LINK_CLK_I,
    input  wire logic        BCLK_I,
    output logic             BCLK_O,
    output logic             BCLK_OE_O,
    input  wire logic        FSYNC_I,
    output logic             FSYNC_O,
    output logic             FSYNC_OE_O,
    input  wire logic        DIN_PRI_I,
    input  wire logic        DIN_SEC_I
);

    // ---------------- bus domain ----------------
    rx_cfg_type  rx_cfg;
    ctrl_type    ctrl;
    status_type  status;
    rx_cfg_type  next_rx_cfg;
    ctrl_type    next_ctrl;
    logic [31:0] data_pri;
    logic [31:0] data_sec;
    logic        wr_pend;
    logic [11:0] wr_addr;
    logic        cfg_tgl;
    logic        acc;
    logic        rd_acc;
    logic        rd_pri;
    logic        rd_sec;
    logic        rd_status;
    logic [31:0] rd_mux;
    logic        wtog_s1;
    logic        wtog_s2;
    logic        wtog_s3;
    logic        new_word;

    // ---------------- link domain ----------------
    logic        lrst_s1;
    logic        lrst_n;
    logic [3:0]  pin_s1;
    logic [3:0]  pin_s2;
    logic        ctog_s1;
    logic        ctog_s2;
    logic        ctog_s3;
    rx_cfg_type  l_cfg;
    ctrl_type    l_ctrl;
    logic [3:0]  div_cnt;
    logic        int_bclk;
    logic        int_fs;
    logic [6:0]  bit_idx;
    logic        int_bclk_d;
    logic        int_fs_d;
    logic        use_int_bclk;
    logic        use_int_fs;
    logic        bclk_now;
    logic        bclk_q;
    logic        fs_now;
    logic        fs_lat;
    logic        want_rise;
    logic        latch;
    logic        start;
    logic        right_start;
    logic        slot_right;
    logic [6:0]  pos;
    logic [6:0]  cur_pos;
    logic [6:0]  skip;
    logic [6:0]  last;
    logic        shift;
    logic        done;
    logic        done_q;
    logic        wtog;
    logic        oe_q;
    logic [31:0] lane_word [2];
    rx_word_type link_word;

    assign acc       = HSEL_I && HREADY_I && (HTRANS_I == HTRANS_NONSEQ || HTRANS_I == 2'h3);
    assign rd_acc    = acc && !HWRITE_I;
    assign rd_pri    = rd_acc && reg_hit(HADDR_I[11:0], DATA_PRI_ADDR);
    assign rd_sec    = rd_acc && reg_hit(HADDR_I[11:0], DATA_SEC_ADDR);
    assign rd_status = rd_acc && reg_hit(HADDR_I[11:0], STATUS_ADDR);
    assign new_word  = wtog_s2 ^ wtog_s3;

    // write data phase values, also forwarded to a read in the same cycle
    always_comb begin
        next_rx_cfg = rx_cfg;
        next_ctrl   = ctrl;
        if (wr_pend && reg_hit(wr_addr, RX_CFG_ADDR)) begin
            next_rx_cfg = HWDATA_I[7:0];
        end
        if (wr_pend && reg_hit(wr_addr, CTRL_ADDR)) begin
            next_ctrl = HWDATA_I[5:0];
        end
    end

    always_comb begin
        rd_mux = 32'h0000_0000;
        if (reg_hit(HADDR_I[11:0], RX_CFG_ADDR)) begin
            rd_mux = {24'h00_0000, next_rx_cfg};
        end else if (reg_hit(HADDR_I[11:0], CTRL_ADDR)) begin
            rd_mux = {26'h000_0000, next_ctrl};
        end else if (reg_hit(HADDR_I[11:0], STATUS_ADDR)) begin
            rd_mux = {28'h000_0000, status};
        end else if (reg_hit(HADDR_I[11:0], DATA_PRI_ADDR)) begin
            rd_mux = data_pri;
        end else if (reg_hit(HADDR_I[11:0], DATA_SEC_ADDR)) begin
            rd_mux = data_sec;
        end
    end

    // address phase capture; zero-wait, always OKAY
    always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            wr_pend     <= 1'b0;
            wr_addr     <= 12'h000;
            HRDATA_O    <= 32'h0000_0000;
            HREADYOUT_O <= 1'b1;
            HRESP_O     <= 1'b0;
        end else begin
            wr_pend     <= acc && HWRITE_I;
            wr_addr     <= HADDR_I[11:0];
            HRDATA_O    <= rd_acc ? rd_mux : 32'h0000_0000;
            HREADYOUT_O <= 1'b1;
            HRESP_O     <= 1'b0;
        end
    end

    always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            rx_cfg  <= RX_CFG_RESET;
            ctrl    <= CTRL_RESET;
            cfg_tgl <= 1'b0;
        end else begin
            rx_cfg <= next_rx_cfg;
            ctrl   <= next_ctrl;
            if (wr_pend && (reg_hit(wr_addr, RX_CFG_ADDR) || reg_hit(wr_addr, CTRL_ADDR))) begin
                cfg_tgl <= ~cfg_tgl;
            end
        end
    end

    AST_CFG_WRITE: assert property (@(posedge REF_CLK_I) disable iff (!RST_N_I) // [R4]
        (wr_pend && reg_hit(wr_addr, RX_CFG_ADDR))
            |=> (rx_cfg.rx_msb_slot_offset == $past(HWDATA_I[4:0])) && $changed(cfg_tgl))
        else $error("offset write not stored or not announced");

    // received words from the link, set wins over read clear
    always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            wtog_s1 <= 1'b0;
            wtog_s2 <= 1'b0;
            wtog_s3 <= 1'b0;
        end else begin
            wtog_s1 <= wtog;
            wtog_s2 <= wtog_s1;
            wtog_s3 <= wtog_s2;
        end
    end

    always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            status   <= STATUS_RESET;
            data_pri <= 32'h0000_0000;
            data_sec <= 32'h0000_0000;
        end else begin
            status.pri_valid <= new_word || (status.pri_valid && !rd_pri);
            status.sec_valid <= new_word || (status.sec_valid && !rd_sec);
            status.overrun   <= (new_word && (status.pri_valid || status.sec_valid))
                                || (status.overrun && !rd_status);
            if (new_word) begin
                status.right <= link_word.right;
                data_pri     <= link_word.pri;
                data_sec     <= link_word.sec;
            end
        end
    end

    // ---------------- link domain logic ----------------
    always_ff @(posedge LINK_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            lrst_s1 <= 1'b0;
            lrst_n  <= 1'b0;
        end else begin
            lrst_s1 <= 1'b1;
            lrst_n  <= lrst_s1;
        end
    end

    // pins: {sec data, pri data, frame sync, bit clock}
    always_ff @(posedge LINK_CLK_I or negedge lrst_n) begin
        if (!lrst_n) begin
            pin_s1 <= 4'h0;
            pin_s2 <= 4'h0;
        end else begin
            pin_s1 <= {DIN_SEC_I, DIN_PRI_I, FSYNC_I, BCLK_I};
            pin_s2 <= pin_s1;
        end
    end

    // configuration is loaded once the write toggle has settled
    always_ff @(posedge LINK_CLK_I or negedge lrst_n) begin
        if (!lrst_n) begin
            ctog_s1 <= 1'b0;
            ctog_s2 <= 1'b0;
            ctog_s3 <= 1'b0;
            l_cfg   <= RX_CFG_RESET;
            l_ctrl  <= CTRL_RESET;
        end else begin
            ctog_s1 <= cfg_tgl;
            ctog_s2 <= ctog_s1;
            ctog_s3 <= ctog_s2;
            if (ctog_s2 ^ ctog_s3) begin
                l_cfg  <= rx_cfg;
                l_ctrl <= ctrl;
            end
        end
    end

    // internal bit clock and frame sync for controller mode
    always_ff @(posedge LINK_CLK_I or negedge lrst_n) begin
        if (!lrst_n) begin
            div_cnt  <= 4'h0;
            int_bclk <= 1'b0;
            bit_idx  <= 7'h00;
        end else if (div_cnt == BCLK_HALF_DIV - 4'h1) begin
            div_cnt  <= 4'h0;
            int_bclk <= ~int_bclk;
            if (int_bclk) begin
                bit_idx <= (bit_idx == FRAME_BCLKS - 7'h01) ? 7'h00 : bit_idx + 7'h01;
            end
        end else begin
            div_cnt <= div_cnt + 4'h1;
        end
    end

    always_ff @(posedge LINK_CLK_I or negedge lrst_n) begin
        if (!lrst_n) begin
            int_fs <= 1'b0;
        end else begin
            unique case (l_ctrl.fmt)
                FMT_TDM: int_fs <= (bit_idx == 7'h00);
                FMT_I2S: int_fs <= (bit_idx >= HALF_FRAME);
                default: int_fs <= (bit_idx < HALF_FRAME);
            endcase
        end
    end

    assign BCLK_O     = int_bclk;
    assign FSYNC_O    = int_fs;
    assign BCLK_OE_O  = oe_q;
    assign FSYNC_OE_O = oe_q;

    always_ff @(posedge LINK_CLK_I or negedge lrst_n) begin
        if (!lrst_n) begin
            oe_q <= 1'b0;
        end else begin
            oe_q <= l_ctrl.controller_mode;
        end
    end

    // clock source selection; target mode forces the external pins
    assign use_int_bclk = l_ctrl.controller_mode && l_cfg.rx_internal_bit_clock_select; // [R3] [R8]
    assign use_int_fs   = l_ctrl.controller_mode && l_cfg.rx_internal_frame_sync_select; // [R2] [R8]

    always_ff @(posedge LINK_CLK_I or negedge lrst_n) begin
        if (!lrst_n) begin
            int_bclk_d <= 1'b0;
            int_fs_d   <= 1'b0;
            bclk_now   <= 1'b0;
            bclk_q     <= 1'b0;
            fs_now     <= 1'b0;
        end else begin
            int_bclk_d <= int_bclk;
            int_fs_d   <= int_fs;
            bclk_now   <= use_int_bclk ? int_bclk_d : pin_s2[0]; // [R3]
            fs_now     <= use_int_fs ? int_fs_d : pin_s2[1]; // [R2]
            bclk_q     <= bclk_now;
        end
    end

    assign want_rise = (l_ctrl.bit_clock_polarity == l_cfg.rx_sample_edge_select); // [R1]
    assign latch     = (bclk_now != bclk_q) && (bclk_now == want_rise); // [R1]

    // slot starts from frame sync edges seen at the latch edge
    always_comb begin
        start       = 1'b0;
        right_start = 1'b0;
        if (latch) begin
            unique case (l_ctrl.fmt)
                FMT_TDM: begin
                    start       = fs_now && !fs_lat; // [R5]
                    right_start = 1'b0;
                end
                FMT_I2S: begin
                    start       = fs_now != fs_lat; // [R5]
                    right_start = fs_now;
                end
                default: begin
                    start       = fs_now != fs_lat; // [R5]
                    right_start = !fs_now;
                end
            endcase
        end
    end

    // I2S carries its one-cycle MSB delay on top of the offset
    assign skip    = {2'h0, l_cfg.rx_msb_slot_offset}
                     + ((l_ctrl.fmt == FMT_I2S) ? 7'h01 : 7'h00); // [R4] [R5]
    assign last    = 7'(skip + wl_bits(l_ctrl.word_len) - 7'h01);
    assign cur_pos = start ? 7'h00 : ((pos == POS_MAX) ? pos : pos + 7'h01);
    assign shift   = latch && (cur_pos >= skip) && (cur_pos <= last); // [R4]
    assign done    = shift && (cur_pos == last);

    always_ff @(posedge LINK_CLK_I or negedge lrst_n) begin
        if (!lrst_n) begin
            pos        <= POS_MAX;
            fs_lat     <= 1'b0;
            slot_right <= 1'b0;
        end else if (latch) begin
            pos    <= cur_pos;
            fs_lat <= fs_now;
            if (start) begin
                slot_right <= right_start;
            end
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_lane
            sarx_lane u_lane (
                .clk_i   (LINK_CLK_I),
                .rst_n_i (lrst_n),
                .din_i   (pin_s2[2 + gi]),
                .start_i (start),
                .shift_i (shift), // [R6]
                .done_i  (done),
                .word_o  (lane_word[gi])
            );
        end
    endgenerate

    // word handover: toggle after the lane words are stable
    always_ff @(posedge LINK_CLK_I or negedge lrst_n) begin
        if (!lrst_n) begin
            done_q <= 1'b0;
            wtog   <= 1'b0;
        end else begin
            done_q <= done;
            if (done_q) begin
                wtog <= ~wtog;
            end
        end
    end

    assign link_word = '{right: slot_right, pri: lane_word[0], sec: lane_word[1]};

    AST_EDGE_SELECT: assert property (@(posedge LINK_CLK_I) disable iff (!lrst_n) // [R1]
        latch |-> ($past(bclk_now) != bclk_now)
                  && (bclk_now == (l_ctrl.bit_clock_polarity == l_cfg.rx_sample_edge_select)))
        else $error("data latched on the wrong bit clock edge");

    AST_INT_FSYNC: assert property (@(posedge LINK_CLK_I) disable iff (!lrst_n) // [R2]
        (l_ctrl.controller_mode && l_cfg.rx_internal_frame_sync_select)
            |=> fs_now == $past(int_fs_d))
        else $error("internal frame sync not used");

    AST_EXT_FSYNC: assert property (@(posedge LINK_CLK_I) disable iff (!lrst_n) // [R2]
        (l_ctrl.controller_mode && !l_cfg.rx_internal_frame_sync_select)
            |=> fs_now == $past(pin_s2[1]))
        else $error("external frame sync not used");

    AST_INT_BCLK: assert property (@(posedge LINK_CLK_I) disable iff (!lrst_n) // [R3]
        (l_ctrl.controller_mode && l_cfg.rx_internal_bit_clock_select)
            |=> bclk_now == $past(int_bclk_d))
        else $error("internal bit clock not used");

    AST_TARGET_CLKS: assert property (@(posedge LINK_CLK_I) disable iff (!lrst_n) // [R8]
        !l_ctrl.controller_mode [*2]
            |-> (bclk_now == $past(pin_s2[0])) && (fs_now == $past(pin_s2[1])))
        else $error("target mode not using external clocks");

    AST_MSB_DELAY: assert property (@(posedge LINK_CLK_I) disable iff (!lrst_n) // [R4]
        (start && l_ctrl.fmt != FMT_I2S)
            |-> shift == (l_cfg.rx_msb_slot_offset == 5'h00))
        else $error("slot MSB not delayed by offset");

    AST_I2S_SKIP: assert property (@(posedge LINK_CLK_I) disable iff (!lrst_n) // [R5]
        (start && l_ctrl.fmt == FMT_I2S) |-> !shift)
        else $error("I2S slot sampled at frame sync edge");

    AST_TDM_SLOT0: assert property (@(posedge LINK_CLK_I) disable iff (!lrst_n) // [R5]
        (start && l_ctrl.fmt == FMT_TDM) |=> !slot_right)
        else $error("TDM slot start marked as right slot");

endmodule : sarx_top

// ===== verification/sarx_host_model.sv
// far-side serial audio source: bit clock, frame sync and both data pins
`timescale 1ns/1ns
module sarx_host_model (
    input  wire logic bclk_w_i,
    input  wire logic fsync_w_i,
    output logic      bclk_o,
    output logic      fsync_o,
    output logic      dpri_o,
    output logic      dsec_o
);
    logic [4:0]  off = 5'h00;
    logic [15:0] wp  = 16'h0000;
    logic [15:0] ws  = 16'h0000;
    logic        lr  = 1'b1;
    logic        lead = 1'b0;
    int          cnt = 0;

    initial begin
        bclk_o = 1'b1;
        fsync_o = 1'b0;
        dpri_o = 1'b0;
        dsec_o = 1'b0;
    end

    task automatic cfg(input logic [4:0] o, input logic [15:0] p, input logic [15:0] s,
                       input logic l);
        off = o;
        wp = p;
        ws = s;
        lr = l;
        bclk_o = l;
    endtask : cfg

    // the half with frame sync low carries the inverted words; bits outside the word toggle
    task automatic drive();
        int p;
        // lead adds the one bit clock that I2S puts before the MSB
        p = cnt - int'(off) - int'(lead);
        if (p >= 0 && p < 16) begin
            dpri_o = wp[15 - p] ^ ~fsync_w_i;
            dsec_o = ws[15 - p] ^ ~fsync_w_i;
        end else begin
            dpri_o = cnt[0];
            dsec_o = ~cnt[0];
        end
    endtask : drive

    always @(fsync_w_i) begin
        cnt = 0;
        drive();
    end

    always @(bclk_w_i) begin
        if (bclk_w_i === lr) begin
            cnt++;
        end else begin
            #1;
            drive();
        end
    end

    // one half frame; the clock stands still afterwards
    task automatic half(input logic fs);
        fsync_o = fs;
        repeat (32) begin
            bclk_o = ~lr;
            #160;
            bclk_o = lr;
            #160;
        end
    endtask : half
endmodule : sarx_host_model

// ===== verification/tb.sv
// testbench: register access and slot reception in every edge and clock setting
`timescale 1ns/1ns
module tb;
    import sarx_pkg::*;
    logic        ref_clk  = 1'b0;
    logic        link_clk = 1'b0;
    logic        rst_n    = 1'b0;
    logic        hsel     = 1'b0;
    logic [31:0] haddr    = 32'h0;
    logic [1:0]  htrans   = 2'h0;
    logic        hwrite   = 1'b0;
    logic [31:0] hwdata   = 32'h0;
    logic [31:0] hrdata;
    logic        hready;
    logic        hresp;
    logic        bclk_o, bclk_oe, fsync_o, fsync_oe;
    logic        bclk_m, fsync_m, dpri, dsec;
    wire         bclk_w  = bclk_oe ? bclk_o : bclk_m;
    wire         fsync_w = fsync_oe ? fsync_o : fsync_m;
    int          fail_count = 0;
    int          tests_run  = 0;
    int          cycles     = 0;

    always #50 ref_clk = ~ref_clk;
    initial #7 forever #16 link_clk = ~link_clk;

    sarx_top i_dut (.REF_CLK_I(ref_clk), .RST_N_I(rst_n), .HSEL_I(hsel), .HADDR_I(haddr),
        .HTRANS_I(htrans), .HWRITE_I(hwrite), .HSIZE_I(3'h2), .HWDATA_I(hwdata),
        .HREADY_I(hready), .HRDATA_O(hrdata), .HREADYOUT_O(hready), .HRESP_O(hresp),
        .LINK_CLK_I(link_clk), .BCLK_I(bclk_w), .BCLK_O(bclk_o), .BCLK_OE_O(bclk_oe),
        .FSYNC_I(fsync_w), .FSYNC_O(fsync_o), .FSYNC_OE_O(fsync_oe), .DIN_PRI_I(dpri),
        .DIN_SEC_I(dsec));

    sarx_host_model i_host (.bclk_w_i(bclk_w), .fsync_w_i(fsync_w), .bclk_o(bclk_m),
        .fsync_o(fsync_m), .dpri_o(dpri), .dsec_o(dsec));

    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
        tests_run++;
        if (s !== e) begin
            fail_count++;
            $display("Error %s expected %h seen %h", n, e, s);
        end
    endtask : chk

    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                        output logic [31:0] r);
        hsel <= 1'b1;
        htrans <= HTRANS_NONSEQ;
        haddr <= {20'h0, a};
        hwrite <= w;
        do @(posedge ref_clk); while (hready !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge ref_clk); while (hready !== 1'b1);
        r = hrdata;
    endtask : xfer

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] r;
        xfer(1'b1, a, d, r);
    endtask : wr

    task automatic rd(input logic [11:0] a, output logic [31:0] r);
        xfer(1'b0, a, 32'h0, r);
    endtask : rd

    task automatic cfg_set(input logic [7:0] c, input logic [7:0] x);
        wr(RX_CFG_ADDR, {24'h0, x});
        repeat (3) @(posedge ref_clk);
        wr(CTRL_ADDR, {24'h0, c});
        repeat (4) @(posedge ref_clk);
    endtask : cfg_set

    task automatic poll(output logic [31:0] st);
        st = 32'h0;
        for (int i = 0; i < 300 && st[0] !== 1'b1; i++) begin
            rd(STATUS_ADDR, st);
        end
    endtask : poll

    // an I2S frame opens with its right slot while the frame sync is high
    task automatic rx_pair(input logic [15:0] p, input logic [15:0] s, input logic i2s);
        logic [31:0] r;
        for (int h = 0; h < 2; h++) begin
            i_host.half(h == 0);
            @(posedge ref_clk);
            poll(r);
            chk("status", {29'h0, r[2:0]}, {29'h0, h[0] ^ i2s, 2'h3});
            rd(DATA_PRI_ADDR, r);
            chk("pri word", r, {16'h0, h[0] ? ~p : p});
            rd(DATA_SEC_ADDR, r);
            chk("sec word", r, {16'h0, h[0] ? ~s : s});
        end
    endtask : rx_pair

    task automatic t_regs();
        logic [31:0] r;
        chk("oe in reset", {30'h0, bclk_oe, fsync_oe}, 32'h0);
        rd(RX_CFG_ADDR, r);
        chk("rx cfg reset", r, 32'h0);
        wr(RX_CFG_ADDR, 32'hBF);
        rd(RX_CFG_ADDR, r);
        chk("rx cfg rw", r, 32'hBF);
        rd(12'h000, r);
        chk("unmapped", r, 32'h0);
        chk("hresp", {31'h0, hresp}, 32'h0);
        wr(RX_CFG_ADDR, 32'h0);
        repeat (3) @(posedge ref_clk);
    endtask : t_regs

    // every polarity and edge pair, offsets put the 16-bit word at both ends of a 32-bit slot
    task automatic t_edges();
        logic [4:0]  offs [4] = '{5'h00, 5'h01, 5'h10, 5'h07};
        logic [15:0] p;
        for (int k = 0; k < 4; k++) begin
            p = 16'hB38E ^ {4{k[3:0]}};
            i_host.cfg(offs[k], p, {p[7:0], p[15:8]}, k[1] == k[0]);
            cfg_set({4'h2, k[1], 1'b0}, {k[0], 2'h0, offs[k]});
            rx_pair(p, {p[7:0], p[15:8]}, 1'b0);
        end
    endtask : t_edges

    task automatic t_target();
        i_host.cfg(5'h03, 16'h8001, 16'h7FFE, 1'b1);
        cfg_set(8'h08, 8'h63);
        rx_pair(16'h8001, 16'h7FFE, 1'b0);
    endtask : t_target

    // I2S puts the MSB one bit clock late; TDM takes one slot per frame
    task automatic t_formats();
        logic [31:0] r;
        i_host.cfg(5'h05, 16'h5AC3, 16'h9617, 1'b1);
        i_host.lead = 1'b1;
        cfg_set(8'h04, 8'h05);
        rx_pair(16'h5AC3, 16'h9617, 1'b1);
        i_host.lead = 1'b0;
        cfg_set(8'h00, 8'h05);
        i_host.half(1'b1);
        @(posedge ref_clk);
        poll(r);
        chk("tdm status", {29'h0, r[2:0]}, 32'h3);
        rd(DATA_PRI_ADDR, r);
        chk("tdm pri", r, 32'h5AC3);
        rd(DATA_SEC_ADDR, r);
        chk("tdm sec", r, 32'h9617);
        i_host.half(1'b0);
        repeat (8) @(posedge ref_clk);
        rd(STATUS_ADDR, r);
        chk("tdm one slot", {29'h0, r[2:0]}, 32'h0);
    endtask : t_formats

    // controller mode: the host follows whichever clocks are on the wires
    task automatic t_ctrl();
        logic [31:0] r;
        i_host.cfg(5'h02, 16'hC35A, 16'h1E69, 1'b1);
        for (int s = 0; s < 4; s++) begin
            cfg_set(8'h09, {1'b0, s[1:0], 5'h02});
            chk("oe ctrl", {30'h0, bclk_oe, fsync_oe}, 32'h3);
            poll(r);
            chk("ctrl valid", {31'h0, r[0]}, 32'h1);
            rd(DATA_PRI_ADDR, r);
            chk("ctrl pri", {31'h0, r === 32'hC35A || r === 32'h3CA5}, 32'h1);
            rd(DATA_SEC_ADDR, r);
            chk("ctrl sec", {31'h0, r === 32'h1E69 || r === 32'hE196}, 32'h1);
            cfg_set(8'h08, {1'b0, s[1:0], 5'h02});
            chk("oe target", {30'h0, bclk_oe, fsync_oe}, 32'h0);
        end
    endtask : t_ctrl

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : report_and_stop

    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 20000) begin
            fail_count++;
            report_and_stop();
        end
    end

    initial begin
        repeat (5) @(posedge ref_clk);
        rst_n <= 1'b1;
        @(posedge ref_clk);
        t_regs();
        t_edges();
        t_target();
        t_formats();
        t_ctrl();
        report_and_stop();
    end
endmodule : tb
